// ---- sim/cra_link_sva.sv ----
// checker: link protocol properties between requester and configuration end
// assumes plain inputs taken from the shared link interface
`timescale 1ns/10ps
module cra_link_sva
  import cra_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RST_B,
  input wire logic req_valid,
  input wire logic req_ctrl,
  input wire logic [7:0] req_data,
  input wire logic req_ready,
  input wire logic rsp_valid,
  input wire logic rsp_ctrl,
  input wire logic [7:0] rsp_data,
  input wire logic [23:0] rsp_dest,
  input wire logic rsp_ready,
  input wire logic ps_valid,
  input wire logic [15:0] ps_res,
  input wire logic ps_done,
  input wire logic ps_ok
);
  // ----------------------------------------
  // message tracking
  // ----------------------------------------
  logic in_msg;
  logic [1:0] id_cnt;
  logic [23:0] id_cap;
  wire logic tok_take = req_valid & req_ready;
  wire logic end_take = tok_take & req_ctrl & (req_data == TOK_END);
  wire logic rsp_take = rsp_valid & rsp_ready & rsp_ctrl;
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      in_msg <= 1'b0;
    end else if (end_take) begin
      in_msg <= 1'b0;
    end else if (tok_take & req_ctrl) begin
      in_msg <= 1'b1;
    end
  end
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      id_cnt <= 2'h0;
      id_cap <= 24'h000000;
    end else if (tok_take & req_ctrl) begin
      id_cnt <= 2'h0;
    end else if (tok_take & (id_cnt != 2'h3)) begin
      id_cnt <= id_cnt + 2'h1;
      id_cap <= {id_cap[15:0], req_data};
    end
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_B);
  end_drop_a: assert property (end_take && in_msg |=> !req_ready)
    else $error("request ready stayed high after closing token");
  reply_start_a: assert property (end_take && in_msg |=> rsp_valid && rsp_ctrl &&
    (rsp_data == TOK_ACK || rsp_data == TOK_NAK)) else $error("no status token after closing token");
  no_early_a: assert property (in_msg |-> !rsp_valid)
    else $error("reply started before closing token");
  reply_dest_a: assert property (rsp_valid |-> rsp_dest == id_cap)
    else $error("reply sent to wrong channel end");
  rsp_hold_a: assert property (rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_data))
    else $error("reply token changed before taken");
  nak_close_a: assert property (rsp_take && rsp_data == TOK_NAK |=> rsp_valid && rsp_ctrl &&
    rsp_data == TOK_END) else $error("failure token not followed by end token");
  reply_done_a: assert property (rsp_take && rsp_data == TOK_END |=> !rsp_valid && req_ready)
    else $error("link not idle after reply end");
  ps_answer_a: assert property (ps_valid && !ps_done |=> ps_done ##1 !ps_done)
    else $error("status access not answered in one cycle");
  ps_refuse_a: assert property (ps_valid && !ps_done && ps_res[7:0] != PS_RES_LOW |=> !ps_ok)
    else $error("bad status resource accepted");
  ps_range_a: assert property (ps_valid && !ps_done && {8'h00, ps_res[15:8]} >= NUM_WORDS |=> !ps_ok)
    else $error("missing status register accepted");
endmodule : cra_link_sva

// ---- sim/testbench.sv ----
// testbench: requester and configuration end joined by the link interface
// assumes one 250 MHz clock and active-low asynchronous reset
`timescale 1ns/10ps
module testbench;
  import cra_pkg::*;
  logic ref_clk, rst_b, cmd_valid, cmd_ready, rsp_valid, rsp_ok, busy;
  cra_kind_t cmd_kind;
  logic [15:0] cmd_id, cmd_reg, ps_seen;
  logic [7:0] cmd_periph, cmd_size;
  logic [31:0] cmd_wdata, rsp_rdata, tile_ctrl, dest_seen;
  logic [8:0] tx_q[$], rx_q[$], e[$];
  int err_count, compares, busy_n;
  localparam logic [8:0] I0 = {1'b0, OWN_CHAN_ID[23:16]};
  localparam logic [8:0] I1 = {1'b0, OWN_CHAN_ID[15:8]};
  localparam logic [8:0] I2 = {1'b0, OWN_CHAN_ID[7:0]};
  cra_link_if link();
  cra_device i_cra_device(.REF_CLK(ref_clk), .RST_B(rst_b), .LINK(link), .TILE_CTRL(tile_ctrl), .BUSY(busy));
  cra_requester i_cra_requester(.REF_CLK(ref_clk), .RST_B(rst_b), .LINK(link), .CMD_VALID(cmd_valid),
    .CMD_KIND(cmd_kind), .CMD_ID(cmd_id), .CMD_PERIPH(cmd_periph), .CMD_REG(cmd_reg), .CMD_SIZE(cmd_size),
    .CMD_WDATA(cmd_wdata), .CMD_READY(cmd_ready), .RSP_VALID(rsp_valid), .RSP_OK(rsp_ok), .RSP_RDATA(rsp_rdata));
  cra_link_sva i_cra_link_sva(.REF_CLK(ref_clk), .RST_B(rst_b), .req_valid(link.req_valid),
    .req_ctrl(link.req_ctrl), .req_data(link.req_data), .req_ready(link.req_ready), .rsp_valid(link.rsp_valid),
    .rsp_ctrl(link.rsp_ctrl), .rsp_data(link.rsp_data), .rsp_dest(link.rsp_dest), .rsp_ready(link.rsp_ready),
    .ps_valid(link.ps_valid), .ps_res(link.ps_res), .ps_done(link.ps_done), .ps_ok(link.ps_ok));
  always #2 ref_clk = ~ref_clk;
  // ----------------------------------------
  // wire monitor
  // ----------------------------------------
  always @(posedge ref_clk) begin
    if (link.req_valid && link.req_ready) begin
      tx_q.push_back({link.req_ctrl, link.req_data});
      dest_seen = link.dest;
    end
    if (link.rsp_valid && link.rsp_ready && link.rsp_dest == OWN_CHAN_ID) begin
      rx_q.push_back({link.rsp_ctrl, link.rsp_data});
    end
    if (busy) begin
      busy_n++;
    end
    if (link.ps_valid) begin
      ps_seen = link.ps_res;
    end
  end
  // ----------------------------------------
  // compare and command tasks
  // ----------------------------------------
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_val
  task automatic chk_toks(input logic [8:0] got[$], input logic [8:0] exp[$]);
    chk_val(32'(got.size()), 32'(exp.size()));
    foreach (exp[i]) begin
      chk_val({23'h0, got[i]}, {23'h0, exp[i]});
    end
  endtask : chk_toks
  task automatic run(input cra_kind_t k, input logic [15:0] r, input logic [7:0] sz, input logic [31:0] wd,
    input logic ok);
    int n;
    tx_q.delete();
    rx_q.delete();
    busy_n = 0;
    @(posedge ref_clk);
    cmd_valid <= 1'b1;
    cmd_kind <= k;
    cmd_reg <= r;
    cmd_size <= sz;
    cmd_wdata <= wd;
    n = 0;
    do begin @(negedge ref_clk); n++; end while (cmd_ready !== 1'b1 && n < 100);
    @(posedge ref_clk);
    cmd_valid <= 1'b0;
    n = 0;
    do begin @(negedge ref_clk); n++; end while (rsp_valid !== 1'b1 && n < 300);
    chk_val({31'h0, rsp_valid}, 32'h1);
    chk_val({31'h0, rsp_ok}, {31'h0, ok});
    chk_val({31'h0, busy}, 32'h0);
    chk_val({31'h0, cmd_ready}, 32'h1);
  endtask : run
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_tile();
    run(K_TILE_WR, 16'h0000, 8'h00, 32'h1234_5678, 1'b1);
    chk_val(dest_seen, {16'h0005, DEST_TILE});
    e = '{9'h1C0, I0, I1, I2, 9'h000, 9'h000, 9'h012, 9'h034, 9'h056, 9'h078, 9'h101};
    chk_toks(tx_q, e);
    e = '{9'h103, 9'h101};
    chk_toks(rx_q, e);
    chk_val(busy_n, 32'(e.size()));
    chk_val(tile_ctrl, 32'h1234_5678);
    run(K_TILE_RD, 16'h0000, 8'h00, 32'h0000_0000, 1'b1);
    e = '{9'h1C1, I0, I1, I2, 9'h000, 9'h000, 9'h101};
    chk_toks(tx_q, e);
    e = '{9'h103, 9'h012, 9'h034, 9'h056, 9'h078, 9'h101};
    chk_toks(rx_q, e);
    chk_val(rsp_rdata, 32'h1234_5678);
    chk_val(busy_n, 32'(e.size()));
  endtask : t_tile
  task automatic t_node();
    run(K_NODE_WR, 16'h0007, 8'h00, 32'hA5A5_0F0F, 1'b1);
    chk_val(dest_seen, {16'h0005, DEST_NODE});
    run(K_NODE_RD, 16'h0007, 8'h00, 32'h0000_0000, 1'b1);
    chk_val(rsp_rdata, 32'hA5A5_0F0F);
    run(K_NODE_RD, 16'h0008, 8'h00, 32'h0000_0000, 1'b0);
    e = '{9'h104, 9'h101};
    chk_toks(rx_q, e);
    run(K_NODE_WR, 16'h0008, 8'h00, 32'hFFFF_FFFF, 1'b0);
    chk_toks(rx_q, e);
  endtask : t_node
  task automatic t_periph();
    run(K_PER_WR, 16'h000C, 8'h04, 32'hA1B2_C3D4, 1'b1);
    chk_val(dest_seen, {16'h0005, 8'h07, DEST_PERIPH});
    e = '{9'h124, I0, I1, I2, 9'h00C, 9'h004, 9'h0A1, 9'h0B2, 9'h0C3, 9'h0D4, 9'h101};
    chk_toks(tx_q, e);
    run(K_PER_RD, 16'h000D, 8'h02, 32'h0000_0000, 1'b1);
    e = '{9'h125, I0, I1, I2, 9'h00D, 9'h002, 9'h101};
    chk_toks(tx_q, e);
    e = '{9'h103, 9'h0B2, 9'h0C3, 9'h101};
    chk_toks(rx_q, e);
    chk_val(rsp_rdata, 32'h0000_B2C3);
    run(K_PER_RD, 16'h000E, 8'h04, 32'h0000_0000, 1'b0);
    e = '{9'h104, 9'h101};
    chk_toks(rx_q, e);
    run(K_PER_WR, 16'h0000, 8'h00, 32'h0000_0011, 1'b0);
  endtask : t_periph
  task automatic t_status();
    run(K_PS_WR, 16'h0003, 8'h00, 32'hCAFE_0001, 1'b1);
    chk_val({16'h0, ps_seen}, (32'h3 << 8) | 32'h0C);
    run(K_PS_RD, 16'h0003, 8'h00, 32'h0000_0000, 1'b1);
    chk_val(rsp_rdata, 32'hCAFE_0001);
    run(K_PS_RD, 16'h0008, 8'h00, 32'h0000_0000, 1'b0);
  endtask : t_status
  // ----------------------------------------
  // run control
  // ----------------------------------------
  task automatic results();
    if (err_count == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : results
  initial begin
    #40000;
    err_count++;
    results();
  end
  initial begin
    ref_clk = 1'b0;
    rst_b = 1'b0;
    cmd_valid = 1'b0;
    cmd_kind = K_TILE_WR;
    cmd_id = 16'h0005;
    cmd_periph = 8'h07;
    cmd_reg = 16'h0000;
    cmd_size = 8'h00;
    cmd_wdata = 32'h0000_0000;
    repeat (10) @(posedge ref_clk);
    rst_b <= 1'b1;
    t_tile();
    t_node();
    t_periph();
    t_status();
    results();
  end
endmodule : testbench

// ---- src/cra_device.sv ----
// configuration end: parses token messages, holds register banks, replies
// assumes requester on the same clock drives the link modport req
`timescale 1ns/10ps
module cra_device (
  input wire logic REF_CLK,
  input wire logic RST_B,
  cra_link_if.dev LINK,
  output logic [31:0] TILE_CTRL,
  output logic BUSY
);
  import cra_pkg::*;

  // ----------------------------------------
  // state and storage
  // ----------------------------------------
  typedef enum {S_CMD, S_RET, S_REG, S_SIZE, S_DATA, S_END, S_DRAIN, S_HDR, S_RDAT, S_TAIL} cra_dstate_t;
  cra_dstate_t state;
  logic [31:0] tile_reg [8];
  logic [31:0] node_reg [8];
  logic [31:0] ps_reg [8];
  logic [7:0] pmem [16];
  logic [2:0] cnt;
  logic [23:0] ret_id;
  logic [15:0] regn;
  logic [7:0] size;
  logic [31:0] wdata;
  logic [31:0] rbuf;
  logic err, is_rd, is_per, is_node, good_q;
  logic acc, is_end, good, reg_ok, commit;
  logic [31:0] rd_word;
  logic [8:0] per_top;

  assign acc = LINK.req_valid && LINK.req_ready;
  assign is_end = LINK.req_ctrl && (LINK.req_data == TOK_END);
  assign per_top = {1'b0, regn[7:0]} + {1'b0, size};
  assign reg_ok = is_per ? (per_top <= NUM_PBYTES) : (regn < NUM_WORDS); // see R13
  assign good = (state == S_END) && !err && reg_ok;
  assign commit = acc && is_end && good && !is_rd;
  assign TILE_CTRL = tile_reg[0];

  always_comb begin
    rd_word = is_node ? node_reg[regn[2:0]] : tile_reg[regn[2:0]];
    if (is_per) begin
      rd_word = 32'h0000_0000;
      for (int k = 0; k < 4; k++) begin
        if (k < size) begin
          rd_word[31 - 8 * k -: 8] = pmem[4'(regn[3:0] + 4'(k))];
        end
      end
    end
  end

  // ----------------------------------------
  // message parser and reply sender
  // ----------------------------------------
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      state <= S_CMD;
      LINK.req_ready <= 1'b1;
      LINK.rsp_valid <= 1'b0;
      LINK.rsp_ctrl <= 1'b0;
      LINK.rsp_data <= 8'h00;
      LINK.rsp_dest <= 24'h00_0000;
      BUSY <= 1'b0;
      cnt <= 3'h0;
      ret_id <= 24'h00_0000;
      regn <= 16'h0000;
      size <= 8'h00;
      wdata <= 32'h0000_0000;
      rbuf <= 32'h0000_0000;
      err <= 1'b0;
      is_rd <= 1'b0;
      is_per <= 1'b0;
      is_node <= 1'b0;
      good_q <= 1'b0;
    end else begin
      if (acc && is_end && state != S_CMD) begin
        // close of frame: reply only now, to the carried id
        state <= S_HDR; // see R12
        LINK.req_ready <= 1'b0;
        BUSY <= 1'b1;
        good_q <= good;
        LINK.rsp_valid <= 1'b1;
        LINK.rsp_ctrl <= 1'b1;
        LINK.rsp_data <= good ? TOK_ACK : TOK_NAK; // see R9
        LINK.rsp_dest <= ret_id; // see R12
        rbuf <= rd_word;
        cnt <= is_per ? 3'(size[2:0] - 3'h1) : 3'h3;
      end else if (acc && LINK.req_ctrl && state != S_CMD && state != S_DRAIN) begin
        err <= 1'b1; // see R13
        state <= S_DRAIN;
      end else if (acc) begin
        case (state)
          S_CMD: begin
            if (LINK.req_ctrl) begin
              cnt <= 3'h2;
              is_rd <= (LINK.req_data == TOK_RD) || (LINK.req_data == TOK_PRD);
              is_per <= (LINK.req_data == TOK_PWR) || (LINK.req_data == TOK_PRD);
              is_node <= (LINK.dest[15:0] == DEST_NODE);
              case (LINK.req_data)
                TOK_WR, TOK_RD: begin
                  state <= S_RET; // see R6
                  err <= (LINK.dest[15:0] != DEST_TILE) && (LINK.dest[15:0] != DEST_NODE);
                end
                TOK_PWR, TOK_PRD: begin
                  state <= S_RET; // see R8
                  err <= (LINK.dest[7:0] != DEST_PERIPH);
                end
                TOK_END: begin
                  state <= S_CMD;
                end
                default: begin
                  state <= S_DRAIN;
                  err <= 1'b1; // see R13
                end
              endcase
            end
          end
          S_RET: begin
            ret_id <= {ret_id[15:0], LINK.req_data};
            cnt <= cnt - 3'h1;
            if (cnt == 3'h0) begin
              state <= S_REG;
              cnt <= is_per ? 3'h0 : 3'h1;
            end
          end
          S_REG: begin
            regn <= {regn[7:0], LINK.req_data};
            cnt <= cnt - 3'h1;
            if (cnt == 3'h0) begin
              if (is_per) begin
                regn <= {8'h00, LINK.req_data};
                state <= S_SIZE;
              end else begin
                state <= is_rd ? S_END : S_DATA; // see R7
                cnt <= 3'h3;
              end
            end
          end
          S_SIZE: begin
            size <= LINK.req_data;
            cnt <= 3'(LINK.req_data[2:0] - 3'h1);
            if (LINK.req_data == 8'h00 || LINK.req_data > MAX_PSIZE) begin
              err <= 1'b1; // see R13
              state <= S_DRAIN;
            end else begin
              state <= is_rd ? S_END : S_DATA; // see R8
            end
          end
          S_DATA: begin
            wdata <= {wdata[23:0], LINK.req_data};
            cnt <= cnt - 3'h1;
            if (cnt == 3'h0) begin
              state <= S_END;
            end
          end
          S_END: begin
            err <= 1'b1; // see R13
            state <= S_DRAIN;
          end
          default: begin
            state <= state;
          end
        endcase
      end else if (LINK.rsp_valid && LINK.rsp_ready) begin
        case (state)
          S_HDR, S_RDAT: begin
            if ((state == S_HDR && good_q && is_rd) || (state == S_RDAT && cnt != 3'h0)) begin
              state <= S_RDAT; // see R10
              LINK.rsp_ctrl <= 1'b0;
              LINK.rsp_data <= rbuf[31:24]; // see R11
              rbuf <= {rbuf[23:0], 8'h00};
              if (state == S_RDAT) begin
                cnt <= cnt - 3'h1;
              end
            end else begin
              state <= S_TAIL;
              LINK.rsp_ctrl <= 1'b1;
              LINK.rsp_data <= TOK_END; // see R9
            end
          end
          S_TAIL: begin
            state <= S_CMD;
            LINK.rsp_valid <= 1'b0;
            LINK.req_ready <= 1'b1;
            BUSY <= 1'b0;
            err <= 1'b0;
          end
          default: begin
            state <= state;
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // configuration banks
  // ----------------------------------------
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      for (int i = 0; i < 8; i++) begin
        tile_reg[i] <= WORD_RESET;
        node_reg[i] <= WORD_RESET;
      end
      for (int j = 0; j < 16; j++) begin
        pmem[j] <= PBYTE_RESET;
      end
    end else if (commit) begin
      if (is_per) begin
        for (int j = 0; j < 16; j++) begin
          if (j >= regn[7:0] && j < per_top) begin
            pmem[j] <= 8'(wdata >> (8 * (size - 8'h01 - 8'(j - regn[7:0])))); // see R8
          end
        end
      end else if (is_node) begin
        node_reg[regn[2:0]] <= wdata; // see R6
      end else begin
        tile_reg[regn[2:0]] <= wdata;
      end
    end
  end

  // ----------------------------------------
  // processor status word port
  // ----------------------------------------
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      for (int i = 0; i < 8; i++) begin
        ps_reg[i] <= WORD_RESET;
      end
      LINK.ps_done <= 1'b0;
      LINK.ps_ok <= 1'b0;
      LINK.ps_rdata <= 32'h0000_0000;
    end else begin
      LINK.ps_done <= 1'b0;
      if (LINK.ps_valid && !LINK.ps_done) begin
        LINK.ps_done <= 1'b1;
        LINK.ps_ok <= 1'b0;
        LINK.ps_rdata <= 32'h0000_0000;
        if (LINK.ps_res[7:0] == PS_RES_LOW && {8'h00, LINK.ps_res[15:PS_SHIFT]} < NUM_WORDS) begin
          LINK.ps_ok <= 1'b1;
          if (LINK.ps_write) begin
            ps_reg[LINK.ps_res[10:8]] <= LINK.ps_wdata; // see R2
          end else begin
            LINK.ps_rdata <= ps_reg[LINK.ps_res[10:8]]; // see R2
          end
        end
      end
    end
  end
endmodule : cra_device

// ---- src/cra_link_if.sv ----
// token link and status-word port between requester and configuration end
// assumes one clock shared by both ends
`timescale 1ns/10ps
interface cra_link_if;
  logic [31:0] dest;
  logic req_valid;
  logic req_ctrl;
  logic [7:0] req_data;
  logic req_ready;
  logic rsp_valid;
  logic rsp_ctrl;
  logic [7:0] rsp_data;
  logic [23:0] rsp_dest;
  logic rsp_ready;
  logic ps_valid;
  logic ps_write;
  logic [15:0] ps_res;
  logic [31:0] ps_wdata;
  logic ps_done;
  logic ps_ok;
  logic [31:0] ps_rdata;
  modport dev (
    input dest, req_valid, req_ctrl, req_data, rsp_ready, ps_valid, ps_write, ps_res, ps_wdata,
    output req_ready, rsp_valid, rsp_ctrl, rsp_data, rsp_dest, ps_done, ps_ok, ps_rdata
  );
  modport req (
    output dest, req_valid, req_ctrl, req_data, rsp_ready, ps_valid, ps_write, ps_res, ps_wdata,
    input req_ready, rsp_valid, rsp_ctrl, rsp_data, rsp_dest, ps_done, ps_ok, ps_rdata
  );
endinterface : cra_link_if

// ---- src/cra_pkg.sv ----
// constants, token codes and command kinds for configuration message access
// assumes both ends share one clock and one active-low reset
// Behaviour
// R1 - status resource id is reg shifted 8, ORed 0x0C
// R2 - status read/write moves one whole word
// R3 - tile destination low half is C20C
// R4 - node destination low half is C30C
// R5 - peripheral destination: node, peripheral byte, 02
// R6 - config write: 192, return id, reg, data, 1
// R7 - config read: 193, return id, reg, 1
// R8 - peripheral 36/37, id, reg, size, data, 1
// R9 - write reply: 3,1 success or 4,1 failure
// R10 - config read reply: 3, word, 1 or 4,1
// R11 - peripheral read reply: 3, bytes, 1 or 4,1
// R12 - reply to carried id, after closing token only
// R13 - bad register or malformed framing gets failure
package cra_pkg;
  // ----------------------------------------
  // tokens
  // ----------------------------------------
  localparam logic [7:0] TOK_WR = 8'hC0;
  localparam logic [7:0] TOK_RD = 8'hC1;
  localparam logic [7:0] TOK_PWR = 8'h24;
  localparam logic [7:0] TOK_PRD = 8'h25;
  localparam logic [7:0] TOK_END = 8'h01;
  localparam logic [7:0] TOK_ACK = 8'h03;
  localparam logic [7:0] TOK_NAK = 8'h04;
  // ----------------------------------------
  // destinations and resource ids
  // ----------------------------------------
  localparam logic [15:0] DEST_TILE = 16'hC20C;
  localparam logic [15:0] DEST_NODE = 16'hC30C;
  localparam logic [7:0] DEST_PERIPH = 8'h02;
  localparam logic [7:0] PS_RES_LOW = 8'h0C;
  localparam int PS_SHIFT = 8;
  // ----------------------------------------
  // sizes and reset values
  // ----------------------------------------
  localparam logic [15:0] NUM_WORDS = 16'h0008;
  localparam logic [8:0] NUM_PBYTES = 9'h010;
  localparam logic [7:0] MAX_PSIZE = 8'h04;
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;
  localparam logic [7:0] PBYTE_RESET = 8'h00;
  localparam logic [23:0] OWN_CHAN_ID = 24'h00_0102;
  localparam int MSG_LEN = 11;
  typedef enum logic [2:0] {
    K_TILE_WR, K_TILE_RD, K_NODE_WR, K_NODE_RD, K_PER_WR, K_PER_RD, K_PS_WR, K_PS_RD
  } cra_kind_t;
endpackage : cra_pkg

// ---- src/cra_requester.sv ----
// requesting channel-end: turns user commands into token messages or status-word port accesses
// assumes configuration end on the same clock drives modport dev
`timescale 1ns/10ps
module cra_requester (
  input wire logic REF_CLK,
  input wire logic RST_B,
  cra_link_if.req LINK,
  input wire logic CMD_VALID,
  input wire cra_pkg::cra_kind_t CMD_KIND,
  input wire logic [15:0] CMD_ID,
  input wire logic [7:0] CMD_PERIPH,
  input wire logic [15:0] CMD_REG,
  input wire logic [7:0] CMD_SIZE,
  input wire logic [31:0] CMD_WDATA,
  output logic CMD_READY,
  output logic RSP_VALID,
  output logic RSP_OK,
  output logic [31:0] RSP_RDATA
);
  import cra_pkg::*;

  typedef enum {Q_IDLE, Q_PS, Q_SEND, Q_WAIT} cra_qstate_t;
  cra_qstate_t state;
  logic [8:0] msg [MSG_LEN];
  logic [8:0] next_msg [MSG_LEN];
  logic [3:0] msg_n, next_n, idx;
  logic [31:0] next_dest;
  logic is_ps;

  assign is_ps = (CMD_KIND == K_PS_WR) || (CMD_KIND == K_PS_RD);

  // ----------------------------------------
  // message builder
  // ----------------------------------------
  always_comb begin
    int n;
    logic wr, per;
    n = 0;
    wr = (CMD_KIND == K_TILE_WR) || (CMD_KIND == K_NODE_WR) || (CMD_KIND == K_PER_WR);
    per = (CMD_KIND == K_PER_WR) || (CMD_KIND == K_PER_RD);
    for (int i = 0; i < MSG_LEN; i++) begin
      next_msg[i] = {1'b1, TOK_END};
    end
    next_dest = {CMD_ID, DEST_TILE}; // see R3
    if (CMD_KIND == K_NODE_WR || CMD_KIND == K_NODE_RD) begin
      next_dest = {CMD_ID, DEST_NODE}; // see R4
    end
    if (per) begin
      next_dest = {CMD_ID, CMD_PERIPH, DEST_PERIPH}; // see R5
      next_msg[0] = {1'b1, wr ? TOK_PWR : TOK_PRD}; // see R8
    end else begin
      next_msg[0] = {1'b1, wr ? TOK_WR : TOK_RD}; // see R6
    end
    next_msg[1] = {1'b0, OWN_CHAN_ID[23:16]};
    next_msg[2] = {1'b0, OWN_CHAN_ID[15:8]};
    next_msg[3] = {1'b0, OWN_CHAN_ID[7:0]};
    if (per) begin
      next_msg[4] = {1'b0, CMD_REG[7:0]};
      next_msg[5] = {1'b0, CMD_SIZE};
      n = 6;
      if (wr) begin
        for (int k = 3; k >= 0; k--) begin
          if (k < CMD_SIZE && k < 4) begin
            next_msg[n] = {1'b0, CMD_WDATA[8 * k +: 8]};
            n = n + 1;
          end
        end
      end
    end else begin
      next_msg[4] = {1'b0, CMD_REG[15:8]};
      next_msg[5] = {1'b0, CMD_REG[7:0]}; // see R7
      n = 6;
      if (wr) begin
        for (int k = 3; k >= 0; k--) begin
          next_msg[n] = {1'b0, CMD_WDATA[8 * k +: 8]};
          n = n + 1;
        end
      end
    end
    next_msg[n] = {1'b1, TOK_END};
    next_n = 4'(n + 1);
  end

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      state <= Q_IDLE;
      CMD_READY <= 1'b1;
      RSP_VALID <= 1'b0;
      RSP_OK <= 1'b0;
      RSP_RDATA <= 32'h0000_0000;
      LINK.dest <= 32'h0000_0000;
      LINK.req_valid <= 1'b0;
      LINK.req_ctrl <= 1'b0;
      LINK.req_data <= 8'h00;
      LINK.rsp_ready <= 1'b0;
      LINK.ps_valid <= 1'b0;
      LINK.ps_write <= 1'b0;
      LINK.ps_res <= 16'h0000;
      LINK.ps_wdata <= 32'h0000_0000;
      msg_n <= 4'h0;
      idx <= 4'h0;
      for (int i = 0; i < MSG_LEN; i++) begin
        msg[i] <= 9'h000;
      end
    end else begin
      RSP_VALID <= 1'b0;
      case (state)
        Q_IDLE: begin
          if (CMD_VALID && CMD_READY) begin
            CMD_READY <= 1'b0;
            RSP_RDATA <= 32'h0000_0000;
            RSP_OK <= 1'b0;
            if (is_ps) begin
              state <= Q_PS;
              LINK.ps_valid <= 1'b1;
              LINK.ps_write <= (CMD_KIND == K_PS_WR);
              LINK.ps_res <= {CMD_REG[7:0], PS_RES_LOW}; // see R1
              LINK.ps_wdata <= CMD_WDATA;
            end else begin
              state <= Q_SEND;
              msg <= next_msg;
              msg_n <= next_n;
              idx <= 4'h0;
              LINK.dest <= next_dest;
              LINK.req_valid <= 1'b1;
              LINK.req_ctrl <= next_msg[0][8];
              LINK.req_data <= next_msg[0][7:0];
            end
          end
        end
        Q_PS: begin
          if (LINK.ps_done) begin
            LINK.ps_valid <= 1'b0;
            state <= Q_IDLE;
            CMD_READY <= 1'b1;
            RSP_VALID <= 1'b1;
            RSP_OK <= LINK.ps_ok;
            RSP_RDATA <= LINK.ps_rdata; // see R2
          end
        end
        Q_SEND: begin
          if (LINK.req_valid && LINK.req_ready) begin
            idx <= idx + 4'h1;
            if (idx == msg_n - 4'h1) begin
              LINK.req_valid <= 1'b0;
              LINK.rsp_ready <= 1'b1;
              state <= Q_WAIT;
            end else begin
              LINK.req_ctrl <= msg[idx + 4'h1][8];
              LINK.req_data <= msg[idx + 4'h1][7:0];
            end
          end
        end
        Q_WAIT: begin
          if (LINK.rsp_valid && LINK.rsp_ready && LINK.rsp_dest == OWN_CHAN_ID) begin
            if (!LINK.rsp_ctrl) begin
              RSP_RDATA <= {RSP_RDATA[23:0], LINK.rsp_data}; // see R10
            end else if (LINK.rsp_data == TOK_ACK) begin
              RSP_OK <= 1'b1; // see R9
            end else if (LINK.rsp_data == TOK_END) begin
              LINK.rsp_ready <= 1'b0;
              state <= Q_IDLE;
              CMD_READY <= 1'b1;
              RSP_VALID <= 1'b1;
            end
          end
        end
        default: begin
          state <= Q_IDLE;
        end
      endcase
    end
  end
endmodule : cra_requester
